// *** src/sector_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sector_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	modport host (output sclk, output cs_n, output mosi, input miso);
	modport device (input sclk, input cs_n, input mosi, output miso);
endinterface
`default_nettype wire

// *** src/sector_map_device.sv ***
// How it works
// - index is arch, location, size bits
// - arch bit: zero hybrid, one uniform
// - location bit: zero bottom, one top
// - size bit: zero 64KB, one 256KB
// - index 00h: bottom, 64KB remainder
// - index 02h: top, 64KB remainder
// - index 01h: bottom, 256KB remainder
// - index 03h: top, 256KB remainder
// - 04h/05h uniform; location ignored when uniform
// - host avoids unsupported bit combinations
// - step one reads 04h, mask 08h
// - step two masks bit 2, 04h
// - descriptors say variable length and latency
// - bit1 zero command; bit0 zero continues
// - second dword holds detection address
// - reserved descriptor fields read as ones
// - location bit read from address 02h
// - last descriptor sets end flag one
`timescale 1ns/1ps
`default_nettype none
module sector_map_device #(
	parameter logic [3:0] DUMMY_CYCLES = sector_map_pkg::LINK_DUMMY_CYCLES
) (
	sector_link_if.device link,
	input wire logic rst_n,
	input wire logic [7:0] nonvol_config_reg_one_in,
	input wire logic [7:0] nonvol_config_reg_three_in,
	output logic [2:0] map_index,
	output logic uniform_arch_select,
	output logic param_sector_top_select,
	output logic [8:0] main_sector_kb,
	output logic map_supported
);
	typedef enum logic [3:0] {
		ST_CMD = 4'b0001,
		ST_ADDR = 4'b0010,
		ST_DUMMY = 4'b0100,
		ST_DATA = 4'b1000
	} dev_state_t;

	dev_state_t state;
	logic [5:0] cnt;
	logic [7:0] opcode;
	logic [31:0] addr;
	logic [31:0] next_addr;
	logic [7:0] dout;
	logic [7:0] one_meta;
	logic [7:0] one_sync;
	logic [7:0] three_meta;
	logic [7:0] three_sync;
	logic cmd_last;
	logic addr_last;
	logic dummy_last;
	logic byte_last;
	logic [2:0] index;

	////////////////////////////////////////////////////////////////////////////
	// byte served for a command and address
	function automatic logic [7:0] read_byte(
		input logic [7:0] op,
		input logic [31:0] a,
		input logic [7:0] one,
		input logic [7:0] three
	);
		logic [31:0] off;
		logic [31:0] word;
		off = a - sector_map_pkg::TABLE_BASE;
		word = 32'h0000_0000;
		read_byte = 8'hff;
		if (op == sector_map_pkg::OP_READ_ANY_REG) begin
			if (a == sector_map_pkg::ADDR_CFG_ONE) begin
				read_byte = one;
			end else if (a == sector_map_pkg::ADDR_CFG_THREE) begin
				read_byte = three;
			end else begin
				read_byte = 8'h00;
			end
		end else if (op == sector_map_pkg::OP_TABLE_READ && a >= sector_map_pkg::TABLE_BASE
				&& off < sector_map_pkg::TABLE_BYTES) begin
			// descriptors: variable length/latency, ones in reserved, end flag last
			word = sector_map_pkg::DETECT_TABLE[off[4:2]];
			read_byte = word[{off[1:0], 3'h0} +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// configuration straps into the link clock domain
	always_ff @(posedge link.sclk) begin
		if (!rst_n) begin
			one_meta <= sector_map_pkg::CFG_ONE_RESET;
			one_sync <= sector_map_pkg::CFG_ONE_RESET;
			three_meta <= sector_map_pkg::CFG_THREE_RESET;
			three_sync <= sector_map_pkg::CFG_THREE_RESET;
		end else begin
			one_meta <= nonvol_config_reg_one_in;
			one_sync <= one_meta;
			three_meta <= nonvol_config_reg_three_in;
			three_sync <= three_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frame position
	always_comb begin
		cmd_last = (state == ST_CMD) && (cnt == sector_map_pkg::CMD_BITS - 6'h01);
		addr_last = (state == ST_ADDR) && (cnt == sector_map_pkg::ADDR_BITS - 6'h01);
		dummy_last = (state == ST_DUMMY) && (cnt == {2'h0, DUMMY_CYCLES - 4'h1});
		byte_last = (state == ST_DATA) && (cnt[2:0] == 3'h7);
		next_addr = {addr[30:0], link.mosi};
	end

	always_ff @(posedge link.sclk) begin
		if (!rst_n || link.cs_n) begin
			state <= ST_CMD;
			cnt <= 6'h00;
		end else begin
			unique case (state)
				ST_CMD: begin
					if (cmd_last) begin
						state <= ST_ADDR;
						cnt <= 6'h00;
					end else begin
						cnt <= cnt + 6'h01;
					end
				end
				ST_ADDR: begin
					if (addr_last) begin
						state <= ST_DUMMY;
						cnt <= 6'h00;
					end else begin
						cnt <= cnt + 6'h01;
					end
				end
				ST_DUMMY: begin
					if (dummy_last) begin
						state <= ST_DATA;
						cnt <= 6'h00;
					end else begin
						cnt <= cnt + 6'h01;
					end
				end
				ST_DATA: begin
					cnt <= {3'h0, cnt[2:0] + 3'h1};
				end
				default: begin
					state <= ST_CMD;
					cnt <= 6'h00;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command and address capture
	always_ff @(posedge link.sclk) begin
		if (!rst_n) begin
			opcode <= 8'h00;
			addr <= 32'h0000_0000;
		end else if (!link.cs_n) begin
			if (state == ST_CMD) begin
				opcode <= {opcode[6:0], link.mosi};
			end
			if (state == ST_ADDR) begin
				addr <= next_addr;
			end else if (byte_last) begin
				addr <= addr + 32'h0000_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data, most significant bit first, address auto-increments
	always_ff @(posedge link.sclk) begin
		if (!rst_n) begin
			dout <= 8'h00;
		end else if (link.cs_n) begin
			dout <= 8'h00;
		end else if (dummy_last) begin
			dout <= read_byte(opcode, addr, one_sync, three_sync);
		end else if (byte_last) begin
			dout <= read_byte(opcode, addr + 32'h0000_0001, one_sync, three_sync);
		end else if (state == ST_DATA) begin
			dout <= {dout[6:0], 1'b0};
		end
	end

	assign link.miso = dout[7];

	////////////////////////////////////////////////////////////////////////////
	// sector layout decode
	assign index = {three_sync[sector_map_pkg::ARCH_BIT], one_sync[sector_map_pkg::TOP_BIT],
		three_sync[sector_map_pkg::SIZE_BIT]};

	always_ff @(posedge link.sclk) begin
		if (!rst_n) begin
			map_index <= 3'h0;
			uniform_arch_select <= 1'b0;
			param_sector_top_select <= 1'b0;
			main_sector_kb <= sector_map_pkg::SECTOR_KB_SMALL;
			map_supported <= 1'b1;
		end else begin
			map_index <= index;
			uniform_arch_select <= index[2];
			unique case (index)
				sector_map_pkg::IDX_BOT_64: begin
					param_sector_top_select <= 1'b0;
					main_sector_kb <= sector_map_pkg::SECTOR_KB_SMALL;
					map_supported <= 1'b1;
				end
				sector_map_pkg::IDX_TOP_64: begin
					param_sector_top_select <= 1'b1;
					main_sector_kb <= sector_map_pkg::SECTOR_KB_SMALL;
					map_supported <= 1'b1;
				end
				sector_map_pkg::IDX_BOT_256: begin
					param_sector_top_select <= 1'b0;
					main_sector_kb <= sector_map_pkg::SECTOR_KB_LARGE;
					map_supported <= 1'b1;
				end
				sector_map_pkg::IDX_TOP_256: begin
					param_sector_top_select <= 1'b1;
					main_sector_kb <= sector_map_pkg::SECTOR_KB_LARGE;
					map_supported <= 1'b1;
				end
				sector_map_pkg::IDX_UNI_64: begin
					param_sector_top_select <= 1'b0;
					main_sector_kb <= sector_map_pkg::SECTOR_KB_SMALL;
					map_supported <= 1'b1;
				end
				sector_map_pkg::IDX_UNI_256: begin
					param_sector_top_select <= 1'b0;
					main_sector_kb <= sector_map_pkg::SECTOR_KB_LARGE;
					map_supported <= 1'b1;
				end
				default: begin
					// uniform with location set: location ignored, map not listed
					param_sector_top_select <= 1'b0;
					main_sector_kb <= index[0] ? sector_map_pkg::SECTOR_KB_LARGE
						: sector_map_pkg::SECTOR_KB_SMALL;
					map_supported <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** src/sector_map_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sector_map_host #(
	parameter int unsigned SCLK_HALF = sector_map_pkg::SCLK_HALF_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	sector_link_if.host link
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b001,
		H_FETCH = 3'b010,
		H_PROBE = 3'b100
	} host_state_t;

	host_state_t state;
	logic ack;
	logic take_wr;
	logic start;
	logic [3:0] lat;
	logic busy;
	logic done;
	logic unsup;
	logic bad;
	logic [2:0] index;
	logic [2:0] next_index;
	logic [31:0] ptr;
	logic [7:0] mask;
	logic last_desc;
	logic [39:0] fr_hdr;
	logic [3:0] fr_bytes;
	logic req;
	logic [63:0] rx;
	logic [31:0] desc;
	logic desc_ok;
	logic [7:0] hc;
	logic tick;
	logic sclk_q;
	logic cs_q;
	logic mosi_q;
	logic active;
	logic pend;
	logic fr_done;
	logic [39:0] hdr;
	logic [6:0] rcnt;
	logic [6:0] hbits;
	logic [6:0] total;
	logic miso_meta;
	logic miso_sync;

	////////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait state per access while clk_en is high; waitrequest holds while clk_en is low
	assign waitrequest = (read || write) && !ack;
	assign take_wr = write && ack;
	assign start = take_wr && address == sector_map_pkg::REG_CTRL
		&& writedata[sector_map_pkg::CTRL_START_BIT] && !busy;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ack <= 1'b0;
			readdata <= 32'h0000_0000;
		end else if (clk_en) begin
			ack <= (read || write) && !ack;
			if (read && !ack) begin
				unique case (address)
					sector_map_pkg::REG_CTRL:
						readdata <= {24'h00_0000, lat, 4'h0};
					sector_map_pkg::REG_STATUS:
						readdata <= {25'h000_0000, index, bad, unsup, done, busy};
					default: readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lat <= sector_map_pkg::LINK_DUMMY_CYCLES;
		end else if (clk_en && take_wr && address == sector_map_pkg::REG_CTRL && !busy) begin
			lat <= writedata[sector_map_pkg::CTRL_LAT_LSB +: 4];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// detection sequence
	// table bytes arrive lowest offset first, so the first byte landed in rx[63:56]
	assign desc = {rx[39:32], rx[47:40], rx[55:48], rx[63:56]};
	assign desc_ok = desc[sector_map_pkg::DESC_KIND_BIT] == 1'b0
		&& desc[sector_map_pkg::DESC_ALEN_LSB +: 2] == sector_map_pkg::ALEN_VARIABLE
		&& desc[sector_map_pkg::DESC_LAT_LSB +: 4] == sector_map_pkg::LAT_VARIABLE;
	assign next_index = {index[1:0], |(rx[7:0] & mask)};

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= H_IDLE;
			busy <= 1'b0;
			done <= 1'b0;
			unsup <= 1'b0;
			bad <= 1'b0;
			index <= 3'h0;
			ptr <= sector_map_pkg::TABLE_BASE;
			mask <= 8'h00;
			last_desc <= 1'b0;
			fr_hdr <= 40'h00_0000_0000;
			fr_bytes <= 4'h0;
			req <= 1'b0;
		end else if (clk_en) begin
			req <= 1'b0;
			unique case (state)
				H_IDLE: begin
					if (start) begin
						state <= H_FETCH;
						busy <= 1'b1;
						done <= 1'b0;
						unsup <= 1'b0;
						bad <= 1'b0;
						index <= 3'h0;
						ptr <= sector_map_pkg::TABLE_BASE;
						fr_hdr <= {sector_map_pkg::OP_TABLE_READ, sector_map_pkg::TABLE_BASE};
						fr_bytes <= sector_map_pkg::DESC_BYTES;
						req <= 1'b1;
					end
				end
				H_FETCH: begin
					if (fr_done && !desc_ok) begin
						state <= H_IDLE;
						busy <= 1'b0;
						done <= 1'b1;
						bad <= 1'b1;
					end else if (fr_done) begin
						state <= H_PROBE;
						mask <= desc[sector_map_pkg::DESC_MASK_LSB +: 8];
						last_desc <= desc[sector_map_pkg::DESC_END_BIT];
						fr_hdr <= {desc[sector_map_pkg::DESC_INSTR_LSB +: 8],
							rx[7:0], rx[15:8], rx[23:16], rx[31:24]};
						fr_bytes <= sector_map_pkg::REG_BYTES;
						req <= 1'b1;
					end
				end
				H_PROBE: begin
					if (fr_done) begin
						index <= next_index;
						if (last_desc) begin
							state <= H_IDLE;
							busy <= 1'b0;
							done <= 1'b1;
							unsup <= next_index > sector_map_pkg::IDX_UNI_256;
						end else begin
							state <= H_FETCH;
							ptr <= ptr + sector_map_pkg::DESC_STRIDE;
							fr_hdr <= {sector_map_pkg::OP_TABLE_READ,
								ptr + sector_map_pkg::DESC_STRIDE};
							fr_bytes <= sector_map_pkg::DESC_BYTES;
							req <= 1'b1;
						end
					end
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// free-running link clock and frame engine
	assign tick = hc == 8'(SCLK_HALF - 1);
	assign hbits = sector_map_pkg::HDR_BITS + {3'h0, lat};
	assign total = hbits + {fr_bytes, 3'h0};

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			miso_meta <= 1'b0;
			miso_sync <= 1'b0;
		end else if (clk_en) begin
			miso_meta <= link.miso;
			miso_sync <= miso_meta;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hc <= 8'h00;
			sclk_q <= 1'b0;
		end else if (clk_en) begin
			hc <= tick ? 8'h00 : hc + 8'h01;
			if (tick) begin
				sclk_q <= !sclk_q;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cs_q <= 1'b1;
			mosi_q <= 1'b0;
			active <= 1'b0;
			pend <= 1'b0;
			fr_done <= 1'b0;
			hdr <= 40'h00_0000_0000;
			rcnt <= 7'h00;
			rx <= 64'h0000_0000_0000_0000;
		end else if (clk_en) begin
			fr_done <= 1'b0;
			if (req) begin
				pend <= 1'b1;
			end
			if (tick && !sclk_q && active) begin
				rcnt <= rcnt + 7'h01;
				if (rcnt >= hbits) begin
					rx <= {rx[62:0], miso_sync};
				end
			end
			if (tick && sclk_q) begin
				if (active && rcnt == total) begin
					cs_q <= 1'b1;
					active <= 1'b0;
					mosi_q <= 1'b0;
					fr_done <= 1'b1;
				end else if (active) begin
					mosi_q <= hdr[39];
					hdr <= {hdr[38:0], 1'b0};
				end else if (pend) begin
					cs_q <= 1'b0;
					active <= 1'b1;
					pend <= 1'b0;
					rcnt <= 7'h00;
					mosi_q <= fr_hdr[39];
					hdr <= {fr_hdr[38:0], 1'b0};
				end
			end
		end
	end

	assign link.sclk = sclk_q;
	assign link.cs_n = cs_q;
	assign link.mosi = mosi_q;
endmodule
`default_nettype wire

// *** src/sector_map_pkg.sv ***
package sector_map_pkg;
	// link commands
	localparam logic [7:0] OP_READ_ANY_REG = 8'h65;
	localparam logic [7:0] OP_TABLE_READ = 8'h5a;
	localparam logic [5:0] CMD_BITS = 6'h08;
	localparam logic [5:0] ADDR_BITS = 6'h20;
	localparam logic [6:0] HDR_BITS = 7'h28;
	localparam logic [3:0] LINK_DUMMY_CYCLES = 4'h8;
	localparam logic [3:0] DESC_BYTES = 4'h8;
	localparam logic [3:0] REG_BYTES = 4'h1;
	////////////////////////////////////////////////////////////////////////////
	// device register addresses
	localparam logic [31:0] ADDR_CFG_ONE = 32'h0000_0002;
	localparam logic [31:0] ADDR_CFG_THREE = 32'h0000_0004;
	localparam logic [7:0] CFG_ONE_RESET = 8'h00;
	localparam logic [7:0] CFG_THREE_RESET = 8'h00;
	localparam int ARCH_BIT = 3;
	localparam int TOP_BIT = 2;
	localparam int SIZE_BIT = 1;
	////////////////////////////////////////////////////////////////////////////
	// detection descriptor table
	localparam logic [31:0] TABLE_BASE = 32'h0000_0048;
	localparam logic [31:0] TABLE_BYTES = 32'h0000_0018;
	localparam logic [31:0] DESC_STRIDE = 32'h0000_0008;
	localparam int TABLE_DWORDS = 6;
	localparam logic [31:0] DETECT_TABLE [TABLE_DWORDS] = '{
		32'h08ff_65fc, 32'h0000_0004,
		32'h04ff_65fc, 32'h0000_0002,
		32'h02ff_65fd, 32'h0000_0004
	};
	localparam int DESC_MASK_LSB = 24;
	localparam int DESC_ALEN_LSB = 22;
	localparam int DESC_LAT_LSB = 16;
	localparam int DESC_INSTR_LSB = 8;
	localparam int DESC_KIND_BIT = 1;
	localparam int DESC_END_BIT = 0;
	localparam logic [1:0] ALEN_VARIABLE = 2'h3;
	localparam logic [3:0] LAT_VARIABLE = 4'hf;
	////////////////////////////////////////////////////////////////////////////
	// map index values and sector sizes
	localparam logic [2:0] IDX_BOT_64 = 3'h0;
	localparam logic [2:0] IDX_BOT_256 = 3'h1;
	localparam logic [2:0] IDX_TOP_64 = 3'h2;
	localparam logic [2:0] IDX_TOP_256 = 3'h3;
	localparam logic [2:0] IDX_UNI_64 = 3'h4;
	localparam logic [2:0] IDX_UNI_256 = 3'h5;
	localparam logic [8:0] SECTOR_KB_SMALL = 9'h040;
	localparam logic [8:0] SECTOR_KB_LARGE = 9'h100;
	////////////////////////////////////////////////////////////////////////////
	// host registers, word addresses
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_LAT_LSB = 4;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;
	localparam int STATUS_UNSUP_BIT = 2;
	localparam int STATUS_BAD_BIT = 3;
	localparam int STATUS_INDEX_LSB = 4;
	localparam int SCLK_HALF_CYCLES = 4;
endpackage

// *** testbench/sector_map_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module sector_map_checker #(
	parameter int LAT = 8
) (
	input wire logic sclk,
	input wire logic dev_rst_n,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso
);
	localparam int DEND = 104 + LAT;
	localparam logic [31:0] EXP_ADDR [6] = '{32'h48, 32'h4, 32'h50, 32'h2, 32'h58, 32'h4};
	logic [7:0] count;
	logic [2:0] fidx;
	logic [39:0] hdr;
	logic [63:0] dat;
	default clocking cb @(posedge sclk); endclocking
	default disable iff (!dev_rst_n);
	////////////////////////////////////////////////////////////////////////////
	// frame bit count, header and reply capture, frame position in the walk
	always_ff @(posedge sclk) begin
		if (!dev_rst_n || cs_n) begin
			count <= 8'h00;
		end else begin
			count <= count + 8'h01;
		end
	end
	always_ff @(posedge sclk) begin
		if (!cs_n && count < 8'h28) begin
			hdr <= {hdr[38:0], mosi};
		end
	end
	always_ff @(posedge sclk) begin
		if (!cs_n && int'(count) >= 40 + LAT && int'(count) < DEND) begin
			dat <= {dat[62:0], miso};
		end
	end
	always_ff @(posedge sclk) begin
		if (!dev_rst_n) begin
			fidx <= 3'h0;
		end else if (cs_n && count != 8'h00) begin
			fidx <= (fidx == 3'h5) ? 3'h0 : fidx + 3'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// assertions
	a_opcode_first: assert property (count == 8'h08 |-> hdr[7:0] == (fidx[0] ? 8'h65 : 8'h5a))
		else $error("wrong opcode for walk position");
	a_frame_header: assert property (count == 8'h28 |-> hdr[31:0] == EXP_ADDR[fidx])
		else $error("detection address out of order");
	a_frame_length: assert property ($rose(cs_n) |-> count == (fidx[0] ? 8'h38 : 8'h70))
		else $error("frame length wrong");
	a_desc_reserved: assert property (int'(count) == DEND && !fidx[0] |->
		dat[63:58] == 6'h3f && !dat[57] && dat[45:44] == 2'h3)
		else $error("descriptor reserved or kind bits wrong");
	a_desc_variable: assert property (int'(count) == DEND && !fidx[0] |->
		dat[47:46] == 2'h3 && dat[43:40] == 4'hf)
		else $error("descriptor length or latency not variable");
	a_desc_instr: assert property (int'(count) == DEND && !fidx[0] |-> dat[55:48] == 8'h65)
		else $error("descriptor instruction wrong");
	a_desc_mask: assert property (int'(count) == DEND && !fidx[0] |->
		dat[39:32] == (8'h08 >> fidx[2:1]))
		else $error("descriptor mask wrong");
	a_desc_address: assert property (int'(count) == DEND && !fidx[0] |->
		dat[31:0] == {(fidx == 3'h2 ? 8'h02 : 8'h04), 24'h0})
		else $error("descriptor address wrong");
	a_desc_end: assert property (int'(count) == DEND && !fidx[0] |-> dat[56] == (fidx == 3'h4))
		else $error("descriptor end flag wrong");
endmodule
`default_nettype wire

// *** testbench/tb_sector_map_config_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_sector_map_config_detect;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic dev_rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [1:0] address = 2'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [7:0] one = 8'h00;
	logic [7:0] three = 8'h00;
	logic [2:0] map_index;
	logic uniform_arch_select;
	logic param_sector_top_select;
	logic [8:0] main_sector_kb;
	logic map_supported;
	int bad_count = 0;
	int cmp_count = 0;
	sector_link_if link_if();
	sector_map_host #(.SCLK_HALF(2)) sector_map_host_inst (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.link(link_if.host)
	);
	sector_map_device sector_map_device_inst (
		.link(link_if.device),
		.rst_n(dev_rst_n),
		.nonvol_config_reg_one_in(one),
		.nonvol_config_reg_three_in(three),
		.map_index(map_index),
		.uniform_arch_select(uniform_arch_select),
		.param_sector_top_select(param_sector_top_select),
		.main_sector_kb(main_sector_kb),
		.map_supported(map_supported)
	);
	sector_map_checker sector_map_checker_inst (
		.sclk(link_if.sclk),
		.dev_rst_n(dev_rst_n),
		.cs_n(link_if.cs_n),
		.mosi(link_if.mosi),
		.miso(link_if.miso)
	);
	always #25 clock = ~clock;
	////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic finish_test;
		$display("mismatches %0d, comparisons %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic bus(input logic [1:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		address <= a;
		write <= w;
		read <= !w;
		writedata <= d;
		@(posedge clock);
		while (waitrequest !== 1'b0) begin
			n++;
			if (n > 200) begin
				bad_count++;
				$display("unexpected at %0t: bus wait ran out", $time);
				finish_test();
			end
			@(posedge clock);
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic bus_regs;
		logic [31:0] q;
		bus(sector_map_pkg::REG_CTRL, 1'b0, 32'h0, q);
		check(q, 32'h0000_0080, "ctrl reset");
		bus(2'h2, 1'b1, 32'hffff_ffff, q);
		bus(2'h2, 1'b0, 32'h0, q);
		check(q, 32'h0, "unmapped read");
		bus(sector_map_pkg::REG_STATUS, 1'b1, 32'hffff_ffff, q);
		bus(sector_map_pkg::REG_STATUS, 1'b0, 32'h0, q);
		check(q, 32'h0, "status after reset");
	endtask
	task automatic stall;
		logic [31:0] q;
		clk_en <= 1'b0;
		fork
			bus(sector_map_pkg::REG_STATUS, 1'b0, 32'h0, q);
			begin
				repeat (4) @(posedge clock);
				check(waitrequest, 1'b1, "stalled wait");
				clk_en <= 1'b1;
			end
		join
	endtask
	task automatic detect(input logic [2:0] idx);
		logic [31:0] q;
		int n;
		one <= 8'hfb | {5'h0, idx[1], 2'h0};
		three <= 8'hf5 | {4'h0, idx[2], 1'b0, idx[0], 1'b0};
		repeat (20) @(posedge clock);
		bus(sector_map_pkg::REG_CTRL, 1'b1, 32'h0000_0081, q);
		bus(sector_map_pkg::REG_CTRL, 1'b1, 32'h0000_0081, q);
		n = 0;
		q = 32'h0;
		while (q[sector_map_pkg::STATUS_DONE_BIT] !== 1'b1) begin
			n++;
			if (n > 3000) begin
				bad_count++;
				$display("unexpected at %0t: detection never finished", $time);
				finish_test();
			end
			bus(sector_map_pkg::REG_STATUS, 1'b0, 32'h0, q);
		end
		check(q[6:0], {idx, 1'b0, idx > 3'h5, 1'b1, 1'b0}, "status");
		check(map_index, idx, "map index");
		check(uniform_arch_select, idx[2], "uniform");
		check(param_sector_top_select, !idx[2] && idx[1], "top");
		check(main_sector_kb, idx[0] ? 9'h100 : 9'h040, "sector size");
		check(map_supported, idx <= 3'h5, "supported");
	endtask
	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		repeat (20) @(posedge clock);
		dev_rst_n <= 1'b1;
		repeat (20) @(posedge clock);
		bus_regs();
		stall();
		for (int i = 0; i < 8; i++) begin
			detect(3'(i));
		end
		finish_test();
	end
endmodule
`default_nettype wire
